// *** crt_consts.svh ***
`ifndef CRT_CONSTS_SVH
`define CRT_CONSTS_SVH

// ----------------------------------------
// field widths
// ----------------------------------------
`define CRT_CHAR_W 7
`define CRT_ROW_W 6
`define CRT_LINE_W 4
`define CRT_HRET_W 5
`define CRT_VRET_W 2
`define CRT_BURST_W 3
`define CRT_SPACE_W 6

// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define CRT_MAX_CHARS 7'h50
`define CRT_MAX_ROWS 6'h3F
`define CRT_MAX_SPACE 6'h37
`define CRT_UL_BLANK_BIT 3
`define CRT_ZERO_LINE 4'h0

`endif

// *** crt_pkg.sv ***
package crt_pkg;

	// ----------------------------------------
	// fetch engine states
	// ----------------------------------------
	typedef enum logic [2:0] {
		CRT_F_IDLE = 3'b001,
		CRT_F_REQ = 3'b010,
		CRT_F_GAP = 3'b100
	} crt_fetch_e;

	// line counter output mode
	typedef enum logic {
		CRT_LC_MODE0 = 1'b0,
		CRT_LC_MODE1 = 1'b1
	} crt_lc_mode_e;

endpackage : crt_pkg

// *** crt_sync2.sv ***
`include "crt_consts.svh"

module crt_sync2
	import crt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// async level in, synced level out
	input wire logic async_in,
	output logic sync_out
);

	logic stage1; // first stage, read only by stage two
	logic next_stage1;
	logic next_sync;

	// ----------------------------------------
	// next values
	// ----------------------------------------
	always_comb begin
		next_stage1 = async_in;
		next_sync = stage1;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync;
		end
	end

endmodule : crt_sync2

// *** crt_fetch.sv ***
`include "crt_consts.svh"

module crt_fetch
	import crt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control from the raster core
	input wire logic char_tick, // one cycle per character clock
	input wire logic row_start, // start filling a new row
	input wire logic fetch_enable, // row needs fetching
	input wire logic [`CRT_CHAR_W-1:0] chars_per_row, // count minus one
	input wire logic [`CRT_BURST_W-1:0] burst_len, // count minus one
	input wire logic [`CRT_SPACE_W-1:0] burst_space,
	// transfer pins, already synchronised
	input wire logic grant_pulse, // one transfer done
	output logic request,
	output logic filled // row buffer full
);

	crt_fetch_e state, next_state;
	logic [`CRT_CHAR_W-1:0] fill_cnt, next_fill_cnt; // characters stored
	logic [`CRT_BURST_W-1:0] burst_cnt, next_burst_cnt; // characters in burst
	logic [`CRT_SPACE_W-1:0] gap_cnt, next_gap_cnt; // gap clocks
	logic next_filled;

	// ----------------------------------------
	// fetch sequencing
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_fill_cnt = fill_cnt;
		next_burst_cnt = burst_cnt;
		next_gap_cnt = gap_cnt;
		next_filled = filled;
		if (row_start) begin
			// new row: first request waits the gap when one is set
			next_fill_cnt = '0;
			next_burst_cnt = '0;
			next_gap_cnt = '0;
			next_filled = !fetch_enable;
			if (!fetch_enable) begin
				next_state = CRT_F_IDLE; // blanked row, no requests
			end else if (burst_space == '0) begin
				next_state = CRT_F_REQ;
			end else begin
				next_state = CRT_F_GAP;
			end
		end else begin
			unique case (state)
				CRT_F_IDLE: begin
					next_state = CRT_F_IDLE;
				end
				CRT_F_REQ: begin
					if (grant_pulse) begin
						next_fill_cnt = fill_cnt + 1'b1;
						next_burst_cnt = burst_cnt + 1'b1;
						if (fill_cnt == chars_per_row) begin
							// full mid burst: stop and clear burst
							next_filled = 1'b1;
							next_burst_cnt = '0;
							next_state = CRT_F_IDLE;
						end else if (burst_cnt == burst_len) begin
							// burst done
							next_burst_cnt = '0;
							next_gap_cnt = '0;
							next_state = (burst_space == '0) ? CRT_F_REQ : CRT_F_GAP;
						end
					end
				end
				CRT_F_GAP: begin
					if (char_tick) begin
						next_gap_cnt = gap_cnt + 1'b1;
						if (gap_cnt + 1'b1 >= burst_space) begin
							next_state = CRT_F_REQ;
						end
					end
				end
				default: begin
					next_state = CRT_F_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// registers; request is high to ask
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= CRT_F_IDLE;
			fill_cnt <= '0;
			burst_cnt <= '0;
			gap_cnt <= '0;
			filled <= 1'b1;
			request <= 1'b0;
		end else begin
			state <= next_state;
			fill_cnt <= next_fill_cnt;
			burst_cnt <= next_burst_cnt;
			gap_cnt <= next_gap_cnt;
			filled <= next_filled;
			request <= (next_state == CRT_F_REQ);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_no_req_when_full;
		@(posedge clk) disable iff (!reset_n)
		(filled && !row_start) |=> !request;
	endproperty
	a_no_req_when_full: assert property (p_no_req_when_full) else $error("request while buffer full");

	property p_blank_no_req;
		@(posedge clk) disable iff (!reset_n)
		(row_start && !fetch_enable) |=> (filled && !request);
	endproperty
	a_blank_no_req: assert property (p_blank_no_req) else $error("request for blanked row");

endmodule : crt_fetch

// *** crt_raster_row_dma_timing.sv ***
`include "crt_consts.svh"

module crt_raster_row_dma_timing
	import crt_pkg::*;
(
	// clock and software reset
	input wire logic clk,
	input wire logic reset_n,
	// character clock pin, asynchronous
	input wire logic char_clock_in,
	// format settings, stable while running
	input wire logic [`CRT_CHAR_W-1:0] chars_per_row, // count minus one
	input wire logic [`CRT_ROW_W-1:0] rows_per_frame, // count minus one
	input wire logic [`CRT_LINE_W-1:0] lines_per_row, // count minus one
	input wire logic [`CRT_HRET_W-1:0] hretrace_len, // count minus one
	input wire logic [`CRT_VRET_W-1:0] vretrace_rows, // count minus one
	input wire logic [`CRT_LINE_W-1:0] underline_line,
	input wire logic line_mode, // 0 or 1
	input wire logic alt_row_blank,
	input wire logic [`CRT_BURST_W-1:0] burst_len, // count minus one
	input wire logic [`CRT_SPACE_W-1:0] burst_space,
	input wire logic irq_enable,
	input wire logic status_read, // one pulse per status read
	// transfer pins
	input wire logic transfer_grant_n_in, // low during a transfer
	output logic transfer_request_out,
	// raster outputs
	output logic [`CRT_LINE_W-1:0] line_address_out,
	output logic video_suppress_out,
	output logic light_enable_out,
	output logic horiz_retrace_out,
	output logic vert_retrace_out,
	output logic disp_buffer_sel, // buffer now shown
	output logic underrun_flag,
	output logic irq_out
);

	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	logic char_clock_in_s, grant_s; // grant_s high while a transfer runs
	logic char_clock_in_d, grant_d;
	logic char_tick, grant_pulse;

	crt_sync2 u_sync_char_clock_in (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(char_clock_in),
		.sync_out(char_clock_in_s)
	);

	crt_sync2 u_sync_grant (
		.clk(clk),
		.reset_n(reset_n),
		// pin inverted so its idle level equals the reset value, no false edge
		.async_in(!transfer_grant_n_in),
		.sync_out(grant_s)
	);

	// rising char clock; grant end = transfer complete
	assign char_tick = char_clock_in_s && !char_clock_in_d;
	assign grant_pulse = !grant_s && grant_d;

	// ----------------------------------------
	// counters
	// ----------------------------------------
	logic [`CRT_CHAR_W-1:0] char_cnt, next_char_cnt; // position in sweep
	logic in_hret, next_in_hret; // horizontal retrace phase
	logic [`CRT_HRET_W-1:0] hret_cnt, next_hret_cnt;
	logic [`CRT_LINE_W-1:0] line_num, next_line_num; // line number in row
	logic [`CRT_ROW_W-1:0] row_cnt, next_row_cnt;
	logic in_vret, next_in_vret; // vertical retrace phase
	logic [`CRT_VRET_W-1:0] vret_cnt, next_vret_cnt;
	logic row_end; // last sweep of row ending
	logic row_tick; // new row time begins
	logic buf_sel, next_buf_sel;

	always_comb begin
		next_char_cnt = char_cnt;
		next_in_hret = in_hret;
		next_hret_cnt = hret_cnt;
		next_line_num = line_num;
		next_row_cnt = row_cnt;
		next_in_vret = in_vret;
		next_vret_cnt = vret_cnt;
		next_buf_sel = buf_sel;
		row_end = 1'b0;
		if (char_tick) begin
			if (!in_hret) begin
				// displayed characters, line held
				if (char_cnt == chars_per_row) begin
					next_in_hret = 1'b1;
					next_hret_cnt = '0;
					// line steps at retrace start
					if (line_num == lines_per_row) begin
						next_line_num = `CRT_ZERO_LINE;
						row_end = 1'b1;
					end else begin
						next_line_num = line_num + 1'b1;
					end
				end else begin
					next_char_cnt = char_cnt + 1'b1;
				end
			end else if (hret_cnt == hretrace_len) begin
				next_in_hret = 1'b0; // retrace done
				next_char_cnt = '0;
			end else begin
				next_hret_cnt = hret_cnt + 1'b1;
			end
		end
		if (row_end) begin
			if (!in_vret) begin
				next_buf_sel = !buf_sel;
				if (row_cnt == rows_per_frame) begin
					next_in_vret = 1'b1;
					next_vret_cnt = '0;
				end else begin
					next_row_cnt = row_cnt + 1'b1;
				end
			end else if (vret_cnt == vretrace_rows) begin
				next_in_vret = 1'b0;
				next_row_cnt = '0;
				next_buf_sel = !buf_sel; // first row buffer goes live
			end else begin
				next_vret_cnt = vret_cnt + 1'b1;
			end
		end
	end

	assign row_tick = row_end;

	// ----------------------------------------
	// fetch control
	// ----------------------------------------
	logic last_vret_row; // one row before retrace ends
	logic fetch_row_odd; // row being fetched is odd
	logic fetch_go;
	logic fetch_start;
	logic filled, req;
	logic [`CRT_ROW_W-1:0] fetch_row;

	assign last_vret_row = next_in_vret && (next_vret_cnt == vretrace_rows);
	// row being fetched is the one after the row now starting
	assign fetch_row = last_vret_row ? '0 : next_row_cnt + 1'b1;
	assign fetch_row_odd = fetch_row[0];
	// first fetch one row before retrace ends, then each row
	assign fetch_start = row_tick && (last_vret_row
		|| (!next_in_vret && next_row_cnt != rows_per_frame));
	assign fetch_go = !(alt_row_blank && fetch_row_odd);

	crt_fetch u_fetch (
		.clk(clk),
		.reset_n(reset_n),
		.char_tick(char_tick),
		.row_start(fetch_start),
		.fetch_enable(fetch_go),
		.chars_per_row(chars_per_row),
		.burst_len(burst_len),
		.burst_space(burst_space),
		.grant_pulse(grant_pulse),
		.request(req),
		.filled(filled)
	);

	// ----------------------------------------
	// video, underline and line address
	// ----------------------------------------
	logic blank_row; // current row blanked by alternate mode
	logic edge_line; // top or bottom line of row
	logic next_vsp, next_light_enable_out, next_ulr, next_irq, next_underrun;
	logic [`CRT_LINE_W-1:0] next_lc;
	logic row_begin_live; // a displayed row starts

	assign blank_row = alt_row_blank && row_cnt[0];
	assign edge_line = (line_num == `CRT_ZERO_LINE) || (line_num == lines_per_row);
	assign row_begin_live = row_tick && !next_in_vret;

	always_comb begin
		// mode 1 lags by one, wraps to last count
		if (line_mode == CRT_LC_MODE1 && next_line_num == `CRT_ZERO_LINE) begin
			next_lc = lines_per_row;
		end else if (line_mode == CRT_LC_MODE1) begin
			next_lc = next_line_num - 1'b1;
		end else begin
			next_lc = next_line_num;
		end
		// suppress: retrace, blanked row, edge lines when underline_line bit 3 is set
		next_vsp = next_in_hret || next_in_vret || blank_row
			|| (underline_line[`CRT_UL_BLANK_BIT] && edge_line);
		// underline on line number, never past row end
		next_light_enable_out = !next_in_hret && !next_in_vret && !blank_row
			&& (line_num == underline_line) && (underline_line <= lines_per_row);
		next_ulr = underrun_flag;
		// underrun: buffer not full when a displayed row ends; blanked fetch reads full
		if (row_end && !in_vret && !filled) begin
			next_ulr = 1'b1;
		end else if (status_read) begin
			next_ulr = 1'b0;
		end
		next_underrun = next_ulr;
		// interrupt at start of last displayed row; set beats clear
		next_irq = irq_out;
		if (status_read) begin
			next_irq = 1'b0;
		end
		if (irq_enable && row_begin_live && next_row_cnt == rows_per_frame) begin
			next_irq = 1'b1;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			char_clock_in_d <= 1'b0;
			grant_d <= 1'b0;
			char_cnt <= '0;
			in_hret <= 1'b0;
			hret_cnt <= '0;
			line_num <= `CRT_ZERO_LINE;
			row_cnt <= '0;
			in_vret <= 1'b1;
			vret_cnt <= '0;
			buf_sel <= 1'b0;
			line_address_out <= `CRT_ZERO_LINE;
			video_suppress_out <= 1'b1;
			light_enable_out <= 1'b0;
			horiz_retrace_out <= 1'b0;
			vert_retrace_out <= 1'b1;
			disp_buffer_sel <= 1'b0;
			underrun_flag <= 1'b0;
			irq_out <= 1'b0; // reset drops interrupt
			transfer_request_out <= 1'b0;
		end else begin
			char_clock_in_d <= char_clock_in_s;
			grant_d <= grant_s;
			char_cnt <= next_char_cnt;
			in_hret <= next_in_hret;
			hret_cnt <= next_hret_cnt;
			line_num <= next_line_num;
			row_cnt <= next_row_cnt;
			in_vret <= next_in_vret;
			vret_cnt <= next_vret_cnt;
			buf_sel <= next_buf_sel;
			line_address_out <= next_lc;
			video_suppress_out <= next_vsp;
			light_enable_out <= next_light_enable_out;
			horiz_retrace_out <= next_in_hret;
			vert_retrace_out <= next_in_vret;
			disp_buffer_sel <= next_buf_sel;
			underrun_flag <= next_underrun;
			irq_out <= next_irq; // high when pending
			transfer_request_out <= req;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_vsp_in_retrace;
		@(posedge clk) disable iff (!reset_n)
		(in_hret || in_vret) |-> video_suppress_out;
	endproperty
	a_vsp_in_retrace: assert property (p_vsp_in_retrace) else $error("suppress low in retrace");

	property p_line_held;
		@(posedge clk) disable iff (!reset_n)
		(!in_hret && $past(!in_hret)) |-> $stable(line_num);
	endproperty
	a_line_held: assert property (p_line_held) else $error("line moved during sweep");

	property p_mode0_addr;
		@(posedge clk) disable iff (!reset_n)
		(line_mode == CRT_LC_MODE0 && $stable(line_num)) |-> (line_address_out == line_num);
	endproperty
	a_mode0_addr: assert property (p_mode0_addr) else $error("mode 0 address wrong");

	property p_mode1_wrap;
		@(posedge clk) disable iff (!reset_n)
		($past(reset_n) && line_mode == CRT_LC_MODE1 && line_num == 4'h0 && $stable(line_num))
			|-> (line_address_out == lines_per_row);
	endproperty
	a_mode1_wrap: assert property (p_mode1_wrap) else $error("mode 1 wrap wrong");

	property p_no_ul_past_row;
		@(posedge clk) disable iff (!reset_n)
		(underline_line > lines_per_row) |=> !light_enable_out;
	endproperty
	a_no_ul_past_row: assert property (p_no_ul_past_row) else $error("underline past row");

	property p_irq_clear;
		@(posedge clk) disable iff (!reset_n)
		(status_read && !(irq_enable && row_begin_live)) |=> !irq_out;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt not dropped");

	property p_irq_set;
		@(posedge clk) disable iff (!reset_n)
		(irq_enable && row_begin_live && next_row_cnt == rows_per_frame) |=> irq_out;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

	property p_swap;
		@(posedge clk) disable iff (!reset_n)
		(row_end && !in_vret) |=> (disp_buffer_sel != $past(disp_buffer_sel));
	endproperty
	a_swap: assert property (p_swap) else $error("buffers did not swap");

endmodule : crt_raster_row_dma_timing

// *** crt_dma_partner.sv ***
module crt_dma_partner (
	// clock
	input wire logic clk,
	// test control: hold off every grant
	input wire logic stall,
	// transfer pins
	input wire logic request,
	output logic grant_n,
	// completed transfers so far
	output int unsigned grants
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// transfer responder
	// ----------------------------------------
	initial begin
		grant_n = 1'b1;
		grants = 0;
	end

	// answer a raised request with one low grant pulse
	always begin
		@(negedge clk);
		if (request === 1'b1 && stall === 1'b0) begin
			repeat (2) @(negedge clk);
			grant_n = 1'b0;
			repeat (4) @(negedge clk);
			grant_n = 1'b1;
			grants++;
			// let the request drop before looking again
			repeat (4) @(negedge clk);
		end
	end
endmodule : crt_dma_partner

// *** crt_raster_row_dma_timing_bench.sv ***
module crt_raster_row_dma_timing_bench
	import crt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// stimulus, outputs, bookkeeping
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic char_clock_in = 1'b0;
	logic [1:0] cdiv = 2'h0; // char clock divider
	logic [6:0] chars_per_row = 7'h03;
	logic [5:0] rows_per_frame = 6'h02;
	logic [3:0] lines_per_row = 4'h2;
	logic [4:0] hretrace_len = 5'h01;
	logic [1:0] vretrace_rows = 2'h0;
	logic [3:0] underline_line = 4'h1;
	logic line_mode = 1'b0;
	logic alt_row_blank = 1'b0;
	logic [2:0] burst_len = 3'h1;
	logic [5:0] burst_space = 6'h02;
	logic irq_enable = 1'b0;
	logic status_read = 1'b0;
	logic stall = 1'b0; // partner stops granting
	logic grant_n;
	logic transfer_request_out;
	logic [3:0] line_address_out;
	logic video_suppress_out;
	logic light_enable_out;
	logic horiz_retrace_out;
	logic vert_retrace_out;
	logic disp_buffer_sel;
	logic underrun_flag;
	logic irq_out;
	int unsigned grants;
	logic [5:0] exp_q[$]; // expected {line, light, suppress}
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] rnd = 8'h16; // lfsr state

	crt_raster_row_dma_timing u_dut (
		.clk(clk), .reset_n(reset_n), .char_clock_in(char_clock_in),
		.chars_per_row(chars_per_row), .rows_per_frame(rows_per_frame),
		.lines_per_row(lines_per_row), .hretrace_len(hretrace_len),
		.vretrace_rows(vretrace_rows), .underline_line(underline_line),
		.line_mode(line_mode), .alt_row_blank(alt_row_blank), .burst_len(burst_len),
		.burst_space(burst_space), .irq_enable(irq_enable), .status_read(status_read),
		.transfer_grant_n_in(grant_n), .transfer_request_out(transfer_request_out),
		.line_address_out(line_address_out), .video_suppress_out(video_suppress_out),
		.light_enable_out(light_enable_out), .horiz_retrace_out(horiz_retrace_out),
		.vert_retrace_out(vert_retrace_out), .disp_buffer_sel(disp_buffer_sel),
		.underrun_flag(underrun_flag), .irq_out(irq_out)
	);

	crt_dma_partner u_dma (
		.clk(clk), .stall(stall), .request(transfer_request_out),
		.grant_n(grant_n), .grants(grants)
	);

	// ----------------------------------------
	// clocks and helpers
	// ----------------------------------------
	always #25 clk = ~clk;

	// character clock at a quarter of clk
	always @(negedge clk) begin
		cdiv <= cdiv + 2'h1;
		char_clock_in <= cdiv[1];
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_line(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_line

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// software reset, released at a falling edge
	task automatic do_reset;
		@(negedge clk);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
	endtask : do_reset

	task automatic pulse_read;
		@(negedge clk);
		status_read = 1'b1;
		@(negedge clk);
		status_read = 1'b0;
	endtask : pulse_read

	// length of the next high phase of a retrace output, suppress-low cycles in it
	task automatic high_len(input logic sel, output int n, output int s);
		n = 0;
		s = 0;
		if (sel) @(posedge vert_retrace_out);
		else @(posedge horiz_retrace_out);
		#1;
		while ((sel ? vert_retrace_out : horiz_retrace_out) === 1'b1 && n < 400) begin
			if (video_suppress_out !== 1'b1) s++;
			@(posedge clk);
			#1;
			n++;
		end
	endtask : high_len

	// one format: a frame of sweeps, then optionally a frame of transfers
	task automatic run_case(input logic mode, input logic [3:0] lpr, input logic [3:0] ul,
		input logic alt, input logic do_cnt);
		int g0;
		int i;
		logic blank;
		logic [3:0] la;
		@(negedge clk);
		reset_n = 1'b0; // format changes only while held in reset
		line_mode = mode;
		lines_per_row = lpr;
		underline_line = ul;
		alt_row_blank = alt;
		do_reset();
		for (int r = 0; r <= 2; r++) begin
			for (int l = 0; l <= lpr; l++) begin
				blank = alt && r[0];
				la = mode ? ((l == 0) ? lpr : 4'(l - 1)) : 4'(l);
				exp_q.push_back({la, !blank && (4'(l) == ul), blank || (ul[3] && (l == 0 || 4'(l) == lpr))});
			end
		end
		for (i = 0; i < 6000 && exp_q.size() > 0; i++) begin
			@(posedge clk);
		end
		check_val(8'(exp_q.size()), 8'h00);
		exp_q.delete();
		if (do_cnt) begin
			@(posedge vert_retrace_out);
			pulse_read();
			g0 = grants;
			@(posedge vert_retrace_out);
			check_val(8'(grants - g0), alt ? 8'h08 : 8'h0C);
			check_val({7'h00, underrun_flag}, 8'h00);
		end
		$display("case mode=%0d lines=%0d ul=%0d alt=%0d done", mode, lpr + 1, ul, alt);
	endtask : run_case

	// ----------------------------------------
	// watcher: one sample in mid sweep
	// ----------------------------------------
	always begin
		@(negedge horiz_retrace_out);
		repeat (6) @(posedge clk);
		#1;
		if (vert_retrace_out === 1'b0 && exp_q.size() > 0) begin
			check_line({line_address_out, light_enable_out, video_suppress_out}, exp_q.pop_front());
		end
	end

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles > 60000) begin
			error_cnt++;
			final_report();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int n;
		int s;
		logic [7:0] r2;
		logic [3:0] ul;
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		run_case(1'b0, 4'h2, 4'h1, 1'b0, 1'b1);
		run_case(1'b0, 4'h2, 4'h1, 1'b1, 1'b1);
		run_case(1'b1, 4'hB, 4'hA, 1'b0, 1'b1);
		run_case(1'b1, 4'h9, 4'hC, 1'b0, 1'b0);
		run_case(1'b1, 4'hF, 4'h7, 1'b0, 1'b0);
		// random formats and burst lengths
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr_next(rnd);
			r2 = lfsr_next(rnd);
			ul = r2[3:0];
			if (ul == rnd[3:0] && ul[3]) ul = ul ^ 4'h1;
			@(negedge clk);
			burst_len = r2[6:4];
			run_case(rnd[4], rnd[3:0], ul, r2[7], 1'b0);
			rnd = r2;
		end
		// stalled supply, interrupt, retrace lengths, status read
		@(negedge clk);
		reset_n = 1'b0; // format changes only while held in reset
		burst_len = 3'h1;
		vretrace_rows = 2'h1;
		lines_per_row = 4'h2;
		alt_row_blank = 1'b0;
		stall = 1'b1;
		do_reset();
		irq_enable = 1'b1;
		@(negedge vert_retrace_out);
		n = 0;
		while (irq_out !== 1'b1 && n < 20) begin
			@(posedge horiz_retrace_out);
			#1;
			n++;
		end
		check_val(8'(n), 8'h06);
		check_val({7'h00, irq_out}, 8'h01);
		check_val({7'h00, disp_buffer_sel}, 8'h01);
		high_len(1'b0, n, s);
		check_val(8'(n), 8'h08);
		check_val(8'(s), 8'h00);
		@(posedge vert_retrace_out);
		#1;
		check_val({7'h00, disp_buffer_sel}, 8'h00);
		high_len(1'b1, n, s);
		check_val(8'(n), 8'h90);
		check_val(8'(s), 8'h00);
		@(negedge horiz_retrace_out);
		check_val({7'h00, underrun_flag}, 8'h01);
		pulse_read();
		repeat (2) @(posedge clk);
		#1;
		check_val({6'h00, irq_out, underrun_flag}, 8'h00);
		$display("stall and interrupt test done");
		final_report();
	end
endmodule : crt_raster_row_dma_timing_bench
